// ---- bcx_defines.svh ----
`ifndef BCX_DEFINES_SVH
`define BCX_DEFINES_SVH

// Primary and extended opcodes
`define BCX_OP_BRANCH_REG   6'h13
`define BCX_OP_EXT31        6'h1F
`define BCX_OP_SCMP_IMM     6'h0B
`define BCX_OP_UCMP_IMM     6'h0A
`define BCX_XO_TO_COUNT     10'h210
`define BCX_XO_TO_LINK      10'h010
`define BCX_XO_SCMP_REG     10'h000
`define BCX_XO_UCMP_REG     10'h020

// Field positions, little-endian index of the field's top bit
`define BCX_F_OPCD          31
`define BCX_F_OPTS          25
`define BCX_F_SEL_IDX       20
`define BCX_F_SRC_A         20
`define BCX_F_BR_RSVD       15
`define BCX_F_XO            10
`define BCX_F_FIELD_SEL     25
`define BCX_F_CMP_RSVD      22
`define BCX_F_IMM           15
`define BCX_F_LINK_FLAG     0

// Bits of branch_options_field, little-endian index in the 5-bit field
`define BCX_OPT_COND_IGN    4
`define BCX_OPT_COND_VAL    3
`define BCX_OPT_COUNT_IGN   2
`define BCX_OPT_COUNT_ZERO  1

// Reset values and address step
`define BCX_COUNT_RST       32'h0000_0000
`define BCX_LINK_RST        32'h0000_0000
`define BCX_COND_RST        32'h0000_0000
`define BCX_ADDR_RST        32'h0000_0000
`define BCX_INSTR_BYTES     32'h0000_0004

`endif

// ---- bcx_pkg.sv ----
package bcx_pkg;

    typedef logic [31:0] bcx_word_t;
    typedef logic [3:0]  bcx_field_t;

    // One-hot kind of the instruction being executed
    typedef enum logic [6:0] {
        BCX_K_NONE     = 7'h01,
        BCX_K_TO_COUNT = 7'h02,
        BCX_K_TO_LINK  = 7'h04,
        BCX_K_SCMP_REG = 7'h08,
        BCX_K_UCMP_REG = 7'h10,
        BCX_K_SCMP_IMM = 7'h20,
        BCX_K_UCMP_IMM = 7'h40
    } bcx_kind_t;

    // Big-endian bit n of a 32-bit register
    function automatic logic bcx_be_bit(input bcx_word_t w,
                                        input logic [4:0] n);
        bcx_be_bit = w[5'd31 - n];
    endfunction : bcx_be_bit

    // Mask of big-endian 4-bit field n, field 0 at the top
    function automatic bcx_word_t bcx_field_mask(input logic [2:0] n);
        bcx_field_mask = 32'hF000_0000 >> {n, 2'b00};
    endfunction : bcx_field_mask

    // Drop a 4-bit result into field n, other fields kept
    function automatic bcx_word_t bcx_field_put(input bcx_word_t w,
                                                input logic [2:0] n,
                                                input bcx_field_t f);
        bcx_field_put = (w & ~bcx_field_mask(n))
                      | ({f, 28'h000_0000} >> {n, 2'b00});
    endfunction : bcx_field_put

endpackage : bcx_pkg

// ---- bcx_ifs.sv ----
`timescale 1ns/1ps

// Operands in, verdict out for the register-target branch evaluator
interface bcx_br_if;
    import bcx_pkg::*;
    logic [4:0] opts;
    logic       cond_bit;
    logic       to_count;
    bcx_word_t  count_old;
    bcx_word_t  link_old;
    bcx_word_t  count_new;
    bcx_word_t  target;
    logic       taken;
    modport core (output opts, cond_bit, to_count, count_old, link_old,
                  input  count_new, target, taken);
    modport eval (input  opts, cond_bit, to_count, count_old, link_old,
                  output count_new, target, taken);
endinterface : bcx_br_if

// Operands in, 4-bit field out for the compare unit
interface bcx_cmp_if;
    import bcx_pkg::*;
    bcx_word_t  op_a;
    bcx_word_t  op_b;
    logic       is_signed;
    logic       sum_ovf;
    bcx_field_t result;
    modport core (output op_a, op_b, is_signed, sum_ovf, input result);
    modport unit (input  op_a, op_b, is_signed, sum_ovf, output result);
endinterface : bcx_cmp_if

// ---- bcx_branch_eval.sv ----
`timescale 1ns/1ps
`include "bcx_defines.svh"

module bcx_branch_eval (
    bcx_br_if.eval br
);
    import bcx_pkg::*;

    wire       dec_en;
    wire       count_ok;
    wire       cond_ok;

    // Decrement happens first so the count test sees the new value
    assign dec_en    = ~br.opts[`BCX_OPT_COUNT_IGN];
    assign br.count_new = dec_en ? br.count_old - 32'h0000_0001
                                 : br.count_old;
    assign count_ok  = br.opts[`BCX_OPT_COUNT_IGN]
                     | ((br.count_new != 32'h0000_0000)
                        ^ br.opts[`BCX_OPT_COUNT_ZERO]);
    assign cond_ok   = br.opts[`BCX_OPT_COND_IGN]
                     | (br.cond_bit == br.opts[`BCX_OPT_COND_VAL]);
    assign br.taken  = count_ok & cond_ok;

    // Count target uses the decremented value in the invalid form
    assign br.target = br.to_count
                     ? {br.count_new[31:2], 2'b00}
                     : {br.link_old[31:2], 2'b00};

endmodule : bcx_branch_eval

// ---- bcx_compare.sv ----
`timescale 1ns/1ps
`include "bcx_defines.svh"

module bcx_compare (
    bcx_cmp_if.unit cmp
);
    import bcx_pkg::*;

    wire lt_s;
    wire gt_s;
    wire lt_u;
    wire gt_u;
    wire eq;

    // Both flavours are built; a mux picks one, cheaper than sharing
    assign lt_s = $signed(cmp.op_a) < $signed(cmp.op_b);
    assign gt_s = $signed(cmp.op_a) > $signed(cmp.op_b);
    assign lt_u = cmp.op_a < cmp.op_b;
    assign gt_u = cmp.op_a > cmp.op_b;
    assign eq   = cmp.op_a == cmp.op_b;

    // Result field: less, greater, equal, summary overflow
    assign cmp.result = {cmp.is_signed ? lt_s : lt_u,
                         cmp.is_signed ? gt_s : gt_u,
                         eq, cmp.sum_ovf};

endmodule : bcx_compare

// ---- bcx_exec.sv ----
`timescale 1ns/1ps
`include "bcx_defines.svh"

// Behaviour
// - Decode op 19 xo 528 as branch-to-count.
// - Count branch target is count upper 30 bits.
// - Link flag loads return address, taken or not.
// - Options bit 2 clear decrements count first.
// - Count test: ignore bit, or nonzero xor bit1.
// - Condition test: ignore bit, or bit matches.
// - Branch only when both tests pass, else next.
// - Decode op 19 xo 16 as branch-to-link.
// - Link branch target is link upper 30 bits.
// - Reserved bits nonzero: no exception raised.
// - Invalid count form targets decremented count.
// - Op 31 xo 0 is signed register compare.
// - Result: less, greater, equal, summary overflow.
// - Only the selected condition field changes.
// - Op 11 compares sign-extended immediate signed.
// - Op 31 xo 32 is unsigned register compare.
// - Op 10 compares zero-extended immediate unsigned.
module bcx_exec (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             instr_valid,
    input  wire bcx_pkg::bcx_word_t instr_word,
    input  wire bcx_pkg::bcx_word_t current_instr_addr,
    input  wire bcx_pkg::bcx_word_t first_source_gpr,
    input  wire bcx_pkg::bcx_word_t second_source_gpr,
    input  wire logic             summary_overflow,
    input  wire logic             count_wr_en,
    input  wire bcx_pkg::bcx_word_t count_wr_data,
    input  wire logic             link_wr_en,
    input  wire bcx_pkg::bcx_word_t link_wr_data,
    input  wire logic             cond_wr_en,
    input  wire bcx_pkg::bcx_word_t cond_wr_data,
    output logic                  next_addr_valid,
    output bcx_pkg::bcx_word_t    next_instr_addr,
    output logic                  branch_taken,
    output logic                  rsvd_nonzero,
    output bcx_pkg::bcx_word_t    count_reg,
    output bcx_pkg::bcx_word_t    link_reg,
    output bcx_pkg::bcx_word_t    condition_reg
);
    import bcx_pkg::*;

    bcx_br_if  br ();
    bcx_cmp_if cmp ();

    logic       next_addr_valid_r, next_addr_valid_nxt;
    bcx_word_t  next_instr_addr_r, next_instr_addr_nxt;
    logic       branch_taken_r, branch_taken_nxt;
    logic       rsvd_nonzero_r, rsvd_nonzero_nxt;
    bcx_word_t  count_reg_r, count_reg_nxt;
    bcx_word_t  link_reg_r, link_reg_nxt;
    bcx_word_t  condition_reg_r, condition_reg_nxt;

    wire [5:0]  opcd;
    wire [9:0]  xo;
    wire [4:0]  branch_options_field;
    wire [4:0]  cond_select_index;
    wire        link_flag;
    wire [2:0]  cond_field_select;
    wire [15:0] imm16;
    wire        is_to_count;
    wire        is_to_link;
    wire        is_scmp_reg;
    wire        is_ucmp_reg;
    wire        is_scmp_imm;
    wire        is_ucmp_imm;
    wire        is_branch;
    wire        is_cmp;
    wire        br_rsvd;
    wire        cmp_rsvd;
    bcx_kind_t  kind;
    bcx_word_t  seq_addr;
    bcx_word_t  imm_sext;
    bcx_word_t  imm_zext;

    // Instruction fields, big-endian bit k sits at index 31-k
    assign opcd  = instr_word[`BCX_F_OPCD -: 6];
    assign xo    = instr_word[`BCX_F_XO -: 10];
    assign branch_options_field = instr_word[`BCX_F_OPTS -: 5];
    assign cond_select_index    = instr_word[`BCX_F_SEL_IDX -: 5];
    assign link_flag            = instr_word[`BCX_F_LINK_FLAG];
    assign cond_field_select    = instr_word[`BCX_F_FIELD_SEL -: 3];
    assign imm16 = instr_word[`BCX_F_IMM -: 16];

    // Opcode decode
    assign is_to_count = instr_valid && opcd == `BCX_OP_BRANCH_REG
                       && xo == `BCX_XO_TO_COUNT;
    assign is_to_link  = instr_valid && opcd == `BCX_OP_BRANCH_REG
                       && xo == `BCX_XO_TO_LINK;
    assign is_scmp_reg = instr_valid && opcd == `BCX_OP_EXT31
                       && xo == `BCX_XO_SCMP_REG;
    assign is_ucmp_reg = instr_valid && opcd == `BCX_OP_EXT31
                       && xo == `BCX_XO_UCMP_REG;
    assign is_scmp_imm = instr_valid && opcd == `BCX_OP_SCMP_IMM;
    assign is_ucmp_imm = instr_valid && opcd == `BCX_OP_UCMP_IMM;
    assign is_branch   = is_to_count | is_to_link;
    assign is_cmp      = is_scmp_reg | is_ucmp_reg
                       | is_scmp_imm | is_ucmp_imm;

    assign kind = is_to_count ? BCX_K_TO_COUNT
                : is_to_link  ? BCX_K_TO_LINK
                : is_scmp_reg ? BCX_K_SCMP_REG
                : is_ucmp_reg ? BCX_K_UCMP_REG
                : is_scmp_imm ? BCX_K_SCMP_IMM
                : is_ucmp_imm ? BCX_K_UCMP_IMM
                : BCX_K_NONE;

    // Reserved bits only raise a status flag, never a trap
    assign br_rsvd  = instr_word[`BCX_F_BR_RSVD -: 5] != 5'h00;
    assign cmp_rsvd = instr_word[`BCX_F_CMP_RSVD -: 2] != 2'h0
                    || ((is_scmp_reg || is_ucmp_reg)
                        && instr_word[`BCX_F_LINK_FLAG]);

    // Operand preparation
    assign seq_addr = current_instr_addr + `BCX_INSTR_BYTES;
    assign imm_sext = {{16{imm16[15]}}, imm16};
    assign imm_zext = {16'h0000, imm16};

    // Branch evaluator sees the register values before this update
    assign br.opts      = branch_options_field;
    assign br.cond_bit  = bcx_be_bit(condition_reg_r,
                                     cond_select_index);
    assign br.to_count  = is_to_count;
    assign br.count_old = count_reg_r;
    assign br.link_old  = link_reg_r;

    assign cmp.op_a      = first_source_gpr;
    assign cmp.op_b      = is_scmp_imm ? imm_sext
                         : is_ucmp_imm ? imm_zext
                         : second_source_gpr;
    assign cmp.is_signed = is_scmp_reg | is_scmp_imm;
    assign cmp.sum_ovf   = summary_overflow;

    bcx_branch_eval u_branch_eval (
        .br (br)
    );

    bcx_compare u_compare (
        .cmp (cmp)
    );

    // Next-address, taken and reserved-bit selection by kind
    always_comb begin
        next_addr_valid_nxt = 1'b1;
        next_instr_addr_nxt = seq_addr;
        branch_taken_nxt    = 1'b0;
        rsvd_nonzero_nxt    = 1'b0;
        case (kind)
            BCX_K_TO_COUNT, BCX_K_TO_LINK: begin
                branch_taken_nxt    = br.taken;
                next_instr_addr_nxt = br.taken ? br.target
                                               : seq_addr;
                rsvd_nonzero_nxt    = br_rsvd;
            end
            BCX_K_SCMP_REG, BCX_K_UCMP_REG,
            BCX_K_SCMP_IMM, BCX_K_UCMP_IMM: begin
                rsvd_nonzero_nxt    = cmp_rsvd;
            end
            default: begin
                next_addr_valid_nxt = 1'b0;
                next_instr_addr_nxt = next_instr_addr_r;
            end
        endcase
    end

    // Architectural registers; an executing instruction wins over a
    // same-cycle write from elsewhere in the core
    assign count_reg_nxt = is_branch   ? br.count_new
                         : count_wr_en ? count_wr_data
                         : count_reg_r;
    assign link_reg_nxt  = (is_branch && link_flag) ? seq_addr
                         : link_wr_en ? link_wr_data
                         : link_reg_r;
    assign condition_reg_nxt = is_cmp
                         ? bcx_field_put(condition_reg_r,
                                         cond_field_select,
                                         cmp.result)
                         : cond_wr_en ? cond_wr_data
                         : condition_reg_r;

    // Result flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            next_addr_valid_r <= 1'b0;
            next_instr_addr_r <= `BCX_ADDR_RST;
            branch_taken_r    <= 1'b0;
            rsvd_nonzero_r    <= 1'b0;
        end else begin
            next_addr_valid_r <= next_addr_valid_nxt;
            next_instr_addr_r <= next_instr_addr_nxt;
            branch_taken_r    <= branch_taken_nxt;
            rsvd_nonzero_r    <= rsvd_nonzero_nxt;
        end
    end

    // Register file flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count_reg_r     <= `BCX_COUNT_RST;
            link_reg_r      <= `BCX_LINK_RST;
            condition_reg_r <= `BCX_COND_RST;
        end else begin
            count_reg_r     <= count_reg_nxt;
            link_reg_r      <= link_reg_nxt;
            condition_reg_r <= condition_reg_nxt;
        end
    end

    assign next_addr_valid = next_addr_valid_r;
    assign next_instr_addr = next_instr_addr_r;
    assign branch_taken    = branch_taken_r;
    assign rsvd_nonzero    = rsvd_nonzero_r;
    assign count_reg       = count_reg_r;
    assign link_reg        = link_reg_r;
    assign condition_reg   = condition_reg_r;

    // Helper: selected-field mask, registered for the checks below
    bcx_word_t field_mask_q;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            field_mask_q <= 32'h0000_0000;
        end else begin
            field_mask_q <= bcx_field_mask(cond_field_select);
        end
    end

    link_load_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_branch && link_flag) |=> link_reg_r == $past(seq_addr))
        else $error("link not loaded with return address");

    count_dec_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_branch && !branch_options_field[`BCX_OPT_COUNT_IGN])
        |=> count_reg_r == $past(count_reg_r) - 32'h0000_0001)
        else $error("count not decremented");

    count_keep_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_branch && branch_options_field[`BCX_OPT_COUNT_IGN])
        |=> $stable(count_reg_r))
        else $error("count changed without decrement");

    fall_through_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_branch && !br.taken)
        |=> !branch_taken_r && next_instr_addr_r == $past(seq_addr))
        else $error("untaken branch did not fall through");

    count_target_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_to_count && br.taken)
        |=> next_instr_addr_r == (count_reg_r & 32'hFFFF_FFFC))
        else $error("count branch target wrong");

    link_target_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_to_link && br.taken)
        |=> next_instr_addr_r == ($past(link_reg_r) & 32'hFFFF_FFFC))
        else $error("link branch target not from old link");

    field_only_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        is_cmp |=> (condition_reg_r & ~field_mask_q)
                   == ($past(condition_reg_r) & ~field_mask_q))
        else $error("compare touched another condition field");

    cmp_signed_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_scmp_reg && cond_field_select == 3'h0)
        |=> condition_reg_r[31] == ($signed($past(first_source_gpr))
                                  < $signed($past(second_source_gpr))))
        else $error("signed less-than bit wrong");

    sum_ovf_copy_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_cmp && cond_field_select == 3'h7)
        |=> condition_reg_r[0] == $past(summary_overflow))
        else $error("summary overflow not copied");

    nonbranch_seq_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        is_cmp |=> next_addr_valid_r && !branch_taken_r)
        else $error("compare reported a branch");

    cmp_unsigned_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_ucmp_reg && cond_field_select == 3'h0)
        |=> condition_reg_r[31] == ($past(first_source_gpr)
                                  < $past(second_source_gpr)))
        else $error("unsigned less-than bit wrong");

    imm_signed_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_scmp_imm && cond_field_select == 3'h0)
        |=> condition_reg_r[31] == ($signed($past(first_source_gpr))
            < $signed({{16{$past(imm16[15])}}, $past(imm16)})))
        else $error("signed immediate less-than bit wrong");

    imm_unsigned_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (is_ucmp_imm && cond_field_select == 3'h0)
        |=> condition_reg_r[31] == ($past(first_source_gpr)
                                  < {16'h0000, $past(imm16)}))
        else $error("unsigned immediate less-than bit wrong");

endmodule : bcx_exec

// ---- bcx_exec_bench.sv ----
`timescale 1ns/1ps

module bcx_exec_bench;
    import bcx_pkg::*;

    logic      sys_clk            = 1'b0;
    logic      reset_n            = 1'b0;
    logic      instr_valid        = 1'b0;
    bcx_word_t instr_word         = '0;
    bcx_word_t current_instr_addr = '0;
    bcx_word_t first_source_gpr   = '0;
    bcx_word_t second_source_gpr  = '0;
    logic      summary_overflow   = 1'b0;
    logic      count_wr_en        = 1'b0;
    bcx_word_t count_wr_data      = '0;
    logic      link_wr_en         = 1'b0;
    bcx_word_t link_wr_data       = '0;
    logic      cond_wr_en         = 1'b0;
    bcx_word_t cond_wr_data       = '0;
    logic      next_addr_valid;
    bcx_word_t next_instr_addr;
    logic      branch_taken;
    logic      rsvd_nonzero;
    bcx_word_t count_reg;
    bcx_word_t link_reg;
    bcx_word_t condition_reg;
    // Expected state kept by the bench
    bcx_word_t m_cnt, m_lnk, m_cr, m_nia, rnd, x, y, z, w, a;
    logic      m_v, m_tk, m_rsv;
    int        fails, n_compared;

    // Clock, 4 ns period
    always #2 sys_clk = ~sys_clk;

    bcx_exec bcx_exec_i (
        .sys_clk            (sys_clk),
        .reset_n            (reset_n),
        .instr_valid        (instr_valid),
        .instr_word         (instr_word),
        .current_instr_addr (current_instr_addr),
        .first_source_gpr   (first_source_gpr),
        .second_source_gpr  (second_source_gpr),
        .summary_overflow   (summary_overflow),
        .count_wr_en        (count_wr_en),
        .count_wr_data      (count_wr_data),
        .link_wr_en         (link_wr_en),
        .link_wr_data       (link_wr_data),
        .cond_wr_en         (cond_wr_en),
        .cond_wr_data       (cond_wr_data),
        .next_addr_valid    (next_addr_valid),
        .next_instr_addr    (next_instr_addr),
        .branch_taken       (branch_taken),
        .rsvd_nonzero       (rsvd_nonzero),
        .count_reg          (count_reg),
        .link_reg           (link_reg),
        .condition_reg      (condition_reg)
    );

    function automatic bcx_word_t lfsr(input bcx_word_t s);
        lfsr = s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
    endfunction : lfsr

    // Compare field, less at the top, overflow copy at the bottom
    function automatic bcx_field_t cmp_res(input bcx_word_t ra, rb,
                                           input logic sg, so);
        logic lt, gt;
        lt = sg ? ($signed(ra) < $signed(rb)) : (ra < rb);
        gt = sg ? ($signed(ra) > $signed(rb)) : (ra > rb);
        cmp_res = {lt, gt, ra == rb, so};
    endfunction : cmp_res

    function automatic bcx_word_t put_fld(input bcx_word_t v,
                                          input logic [2:0] n,
                                          input bcx_field_t f);
        put_fld = v;
        put_fld[31 - 4 * n -: 4] = f;
    endfunction : put_fld

    function automatic bcx_word_t br_w(input logic to_cnt,
                                       input logic [4:0] o, bi,
                                       input logic lk);
        br_w = {6'h13, o, bi, 5'h00, to_cnt ? 10'h210 : 10'h010, lk};
    endfunction : br_w

    // X-form when the opcode is the extended one, else D-form
    function automatic bcx_word_t cmp_w(input logic [5:0] op,
                                        input logic [2:0] f,
                                        input logic [9:0] xo,
                                        input logic [15:0] imm);
        cmp_w = (op == 6'h1F) ? {op, f, 2'b00, 10'h064, xo, 1'b0}
                              : {op, f, 2'b00, 5'h03, imm};
    endfunction : cmp_w

    // Next state from the inputs as they stand before the edge
    task automatic model;
        logic [4:0] o;
        logic [5:0] op;
        logic [9:0] xo;
        logic       br, cp, c_ok, b_ok;
        bcx_word_t  c0, l0, r0, c1, tgt, b;
        o = instr_word[25:21];
        op = instr_word[31:26];
        xo = instr_word[10:1];
        br = op == 6'h13 && (xo == 10'h210 || xo == 10'h010);
        cp = (op == 6'h1F && (xo == 10'h000 || xo == 10'h020))
           || op == 6'h0B || op == 6'h0A;
        c0 = m_cnt;
        l0 = m_lnk;
        r0 = m_cr;
        m_v = 1'b0;
        m_tk = 1'b0;
        m_rsv = 1'b0;
        if (count_wr_en) m_cnt = count_wr_data;
        if (link_wr_en) m_lnk = link_wr_data;
        if (cond_wr_en) m_cr = cond_wr_data;
        if (!reset_n) begin
            {m_cnt, m_lnk, m_cr, m_nia} = '0;
        end else if (instr_valid && br) begin
            c1 = o[2] ? c0 : c0 - 1;
            c_ok = o[2] | ((c1 != 0) ^ o[1]);
            b_ok = o[4] | (r0[31 - instr_word[20:16]] == o[3]);
            m_v = 1'b1;
            m_tk = c_ok & b_ok;
            m_rsv = |instr_word[15:11];
            // Branch owns the count this cycle, even when it keeps it
            m_cnt = c1;
            // Old link value feeds the target even when link is rewritten
            tgt = (xo == 10'h210) ? c1 : l0;
            m_nia = m_tk ? {tgt[31:2], 2'b00} : current_instr_addr + 4;
            if (instr_word[0]) m_lnk = current_instr_addr + 4;
        end else if (instr_valid && cp) begin
            b = (op == 6'h0B) ? {{16{instr_word[15]}}, instr_word[15:0]}
              : (op == 6'h0A) ? {16'h0000, instr_word[15:0]}
              : second_source_gpr;
            m_cr = put_fld(r0, instr_word[25:23],
                           cmp_res(first_source_gpr, b,
                                   op == 6'h0B || (op == 6'h1F && xo == 0),
                                   summary_overflow));
            m_v = 1'b1;
            m_nia = current_instr_addr + 4;
            m_rsv = |instr_word[22:21]
                  | (op == 6'h1F && instr_word[0]);
        end
    endtask : model

    task automatic chk_word(input bcx_word_t got, input bcx_word_t exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag

    // One cycle: model, let the edge land, check, drop write strobes
    task automatic go;
        model;
        @(negedge sys_clk);
        chk_flag(next_addr_valid, m_v);
        chk_flag(branch_taken, m_tk);
        chk_flag(rsvd_nonzero, m_rsv);
        chk_word(next_instr_addr, m_nia);
        chk_word(count_reg, m_cnt);
        chk_word(link_reg, m_lnk);
        chk_word(condition_reg, m_cr);
        count_wr_en = 1'b0;
        link_wr_en = 1'b0;
        cond_wr_en = 1'b0;
    endtask : go

    task automatic op(input bcx_word_t iw, input bcx_word_t ra, rb);
        instr_valid = 1'b1;
        instr_word = iw;
        first_source_gpr = ra;
        second_source_gpr = rb;
        go;
    endtask : op

    task automatic end_sim;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // Cuts a hang short; the full run needs about 2050 cycles
    initial begin
        #40000;
        fails = fails + 1;
        end_sim;
    end

    initial begin
        {m_cnt, m_lnk, m_cr, m_nia} = '0;
        rnd = 32'h0001_0B81;
        repeat (4) go;
        reset_n = 1'b1;
        // Count of one, link and one condition bit preloaded
        {count_wr_en, link_wr_en, cond_wr_en} = 3'b111;
        count_wr_data = 32'h0000_0001;
        link_wr_data = 32'h0000_1237;
        cond_wr_data = 32'h4000_0000;
        go;
        current_instr_addr = 32'h0000_0100;
        op(br_w(1, 5'b10010, 5'd0, 1), '0, '0);
        current_instr_addr = 32'h0000_0200;
        op(br_w(0, 5'b10100, 5'd0, 1), '0, '0);
        op(br_w(1, 5'b00000, 5'd1, 0), '0, '0);
        op(br_w(1, 5'b01000, 5'd1, 0), '0, '0);
        // Instruction update must beat the same-cycle external write
        count_wr_en = 1'b1;
        count_wr_data = 32'h0000_0055;
        op(br_w(1, 5'b10000, 5'd0, 0), '0, '0);
        op(br_w(0, 5'b10100, 5'd0, 0) | 32'h0000_F800, '0, '0);
        op(cmp_w(6'h0B, 3'd5, 10'h000, 16'h8000) | 32'h0060_0000,
           32'hFFFF_8000, '0);
        op({6'h13, 15'h0000, 10'h101, 1'b0}, '0, '0);
        for (int f = 0; f < 8; f++) begin
            summary_overflow = f[0];
            op(cmp_w(6'h1F, f[2:0], 10'h000, 16'h0000),
               32'hFFFF_FFFF, 32'h0000_0001);
            op(cmp_w(6'h1F, f[2:0], 10'h020, 16'h0000),
               32'hFFFF_FFFF, 32'h0000_0001);
            op(cmp_w(6'h0A, f[2:0], 10'h000, 16'hFFFF),
               32'h0000_FFFF, '0);
            op(cmp_w(6'h0B, f[2:0], 10'h000, 16'hFFFF), '0, '0);
        end
        // Random traffic; small count values make the zero test likely
        for (int i = 0; i < 2000; i++) begin
            rnd = lfsr(rnd);
            x = rnd;
            rnd = lfsr(rnd);
            y = rnd;
            rnd = lfsr(rnd);
            z = rnd;
            summary_overflow = z[2];
            count_wr_en = z[5:3] == 3'd0;
            count_wr_data = {29'h0000_0000, y[2:0]};
            link_wr_en = z[8:6] == 3'd0;
            link_wr_data = x;
            cond_wr_en = z[11:9] == 3'd0;
            cond_wr_data = y;
            current_instr_addr = {x[31:2], 2'b00};
            a = (z[13:12] == 2'd0) ? {{16{y[15]}}, y[15:0]}
              : (z[13:12] == 2'd1) ? {16'h0000, y[15:0]} : x;
            case (z[18:16])
                3'd0, 3'd1: w = br_w(z[16], y[25:21], y[30:26], y[31]);
                3'd2: w = cmp_w(6'h1F, y[2:0], 10'h000, y[15:0]);
                3'd3: w = cmp_w(6'h1F, y[2:0], 10'h020, y[15:0]);
                3'd4: w = cmp_w(6'h0B, y[2:0], 10'h000, y[15:0]);
                3'd5: w = cmp_w(6'h0A, y[2:0], 10'h000, y[15:0]);
                3'd6: w = x;
                default: w = br_w(1'b1, y[25:21] | 5'h04, y[30:26], y[31]);
            endcase
            if (z[21:19] == 3'd0)
                w = w | (z[18:17] == 2'd0 ? 32'h0000_F800 : 32'h0060_0000);
            instr_valid = z[0] | z[1];
            instr_word = w;
            first_source_gpr = a;
            second_source_gpr = z[14] ? a : y;
            go;
        end
        instr_valid = 1'b0;
        go;
        end_sim;
    end

endmodule : bcx_exec_bench
